// ==== logic/psm_ctl_if.sv ====
// psm_ctl_if.sv: mode request and wake signals between register file
// and the mode sequencer.
// assumes: both ends share pclk.
`timescale 1ns/100ps
interface psm_ctl_if;
  logic                 idle_req;
  logic                 pdown_req;
  logic                 wake;
  psm_pkg::psm_mode_type mode;

  modport regs (output idle_req, output pdown_req, input wake, input mode);
  modport seq  (input idle_req, input pdown_req, output wake, output mode);
endinterface

// ==== logic/psm_map.svh ====
// psm_map.svh: register offsets, field positions and reset values of the
// power-saving mode controller.
// assumes: included by its bare name from design and bench files.
`ifndef PSM_MAP_SVH
`define PSM_MAP_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define PSM_ADDR_POWER_CTRL   12'h000
`define PSM_ADDR_SYNTH_CTRL   12'h004
`define PSM_ADDR_STATUS       12'h008

// ----------------------------------------------------------------------
// power control register fields
// ----------------------------------------------------------------------
`define PSM_PCTL_IDLE_BIT     0
`define PSM_PCTL_PDOWN_BIT    1
`define PSM_PCTL_SERWAKE_BIT  2
`define PSM_PCTL_EXTWAKE_BIT  3
`define PSM_PCTL_RESET        32'h00000000

// ----------------------------------------------------------------------
// clock synthesiser control fields
// ----------------------------------------------------------------------
`define PSM_SYNTH_OSCSLEEP_BIT 0
`define PSM_SYNTH_RESET        32'h00000000

// ----------------------------------------------------------------------
// pin states while asleep
// ----------------------------------------------------------------------
`define PSM_STROBE_IDLE_LVL   1'h1
`define PSM_STROBE_PDOWN_LVL  1'h0

`endif

// ==== logic/psm_pkg.sv ====
// psm_pkg.sv: types shared by the power-saving mode controller files.
// assumes: nothing beyond the map header.
package psm_pkg;

  // --------------------------------------------------------------------
  // operating modes
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    PSM_NORMAL = 2'b00,
    PSM_IDLE   = 2'b01,
    PSM_PDOWN  = 2'b10
  } psm_mode_type;

endpackage

// ==== logic/psm_seq.sv ====
// psm_seq.sv: mode sequencer, decides mode from requests and wake events.
// assumes: wake inputs are already synchronous to pclk.
`timescale 1ns/100ps
`include "psm_map.svh"
module psm_seq (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // wake sources, already qualified
  input  wire logic any_irq,
  input  wire logic pd_wake,
  // control link
  psm_ctl_if.seq    ctl
);

  psm_pkg::psm_mode_type next_mode;
  psm_pkg::psm_mode_type mode;
  logic                  wake;

  // power-down wins over idle when both are asked for
  always_comb begin
    next_mode = mode;
    case (mode)
      psm_pkg::PSM_NORMAL: begin
        // the mode bits clear one edge after wake; hold normal meanwhile,
        // or the stale bits would send the block straight back to sleep
        if (wake) begin
          next_mode = psm_pkg::PSM_NORMAL;
        end else if (ctl.pdown_req) begin
          next_mode = psm_pkg::PSM_PDOWN;
        end else if (ctl.idle_req) begin
          next_mode = psm_pkg::PSM_IDLE;
        end
      end
      psm_pkg::PSM_IDLE: begin
        if (any_irq) begin
          next_mode = psm_pkg::PSM_NORMAL;
        end
      end
      psm_pkg::PSM_PDOWN: begin
        if (pd_wake) begin
          next_mode = psm_pkg::PSM_NORMAL;
        end
      end
      default: next_mode = psm_pkg::PSM_NORMAL;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= psm_pkg::PSM_NORMAL;
      wake <= 1'b0;
    end else if (clk_en) begin
      mode <= next_mode;
      wake <= (mode != psm_pkg::PSM_NORMAL) && (next_mode == psm_pkg::PSM_NORMAL);
    end
  end

  assign ctl.mode = mode;
  assign ctl.wake = wake;

endmodule

// ==== logic/psm_top.sv ====
// psm_top.sv: power-saving mode controller with APB register access.
// assumes: interrupt inputs come from other clock domains and are
// synchronised here; the core honours core_clk_en as its clock gate.
`timescale 1ns/100ps
`include "psm_map.svh"
module psm_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt wake sources, asynchronous
  input  wire logic        enabled_irq,
  input  wire logic        interval_counter_irq,
  input  wire logic        serial_irq,
  input  wire logic        external_interrupt_zero,
  // normal-mode strobe values from the core
  input  wire logic        core_address_latch_strobe,
  input  wire logic        core_program_store_strobe,
  // clock and pin control
  output logic             core_clk_en,
  output logic             osc_run,
  output logic             synth_run,
  output logic             periph_clk_en,
  output logic             interval_counter_clk_en,
  output logic             pin_hold,
  output logic             dac_out_en,
  output logic             address_latch_strobe,
  output logic             program_store_strobe,
  output logic [1:0]       mode_out
);

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  logic [3:0] irq_meta;
  logic [3:0] irq_sync;
  logic [3:0] irq_raw;

  assign irq_raw = {external_interrupt_zero, serial_irq,
                    interval_counter_irq, enabled_irq};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_meta <= 4'h0;
      irq_sync <= 4'h0;
    end else if (clk_en) begin
      irq_meta <= irq_raw;
      irq_sync <= irq_meta;
    end
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  logic       idle_bit;
  logic       pdown_bit;
  logic       serial_wake_enable;
  logic       external_wake_enable;
  logic       oscillator_sleep_bit;

  wire        apb_access   = psel && penable;
  wire        apb_wr       = apb_access && pwrite;
  wire        sel_pctl     = (paddr == `PSM_ADDR_POWER_CTRL);
  wire        sel_synth    = (paddr == `PSM_ADDR_SYNTH_CTRL);
  wire        sel_status   = (paddr == `PSM_ADDR_STATUS);
  wire        sel_any      = sel_pctl || sel_synth || sel_status;
  wire        wr_pctl      = apb_wr && sel_pctl;
  wire        wr_synth     = apb_wr && sel_synth;

  psm_ctl_if ctl ();

  assign ctl.idle_req  = idle_bit;
  assign ctl.pdown_req = pdown_bit;

  // wake clears the mode bits; it cannot meet a write since the core is
  // stopped while asleep, and the write is given priority if it does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_bit             <= 1'b0;
      pdown_bit            <= 1'b0;
      serial_wake_enable   <= 1'b0;
      external_wake_enable <= 1'b0;
      oscillator_sleep_bit <= 1'b0;
    end else if (clk_en) begin
      if (wr_pctl) begin
        idle_bit             <= pwdata[`PSM_PCTL_IDLE_BIT];
        pdown_bit            <= pwdata[`PSM_PCTL_PDOWN_BIT];
        serial_wake_enable   <= pwdata[`PSM_PCTL_SERWAKE_BIT];
        external_wake_enable <= pwdata[`PSM_PCTL_EXTWAKE_BIT];
      end else if (ctl.wake) begin
        idle_bit  <= 1'b0;
        pdown_bit <= 1'b0;
      end
      if (wr_synth) begin
        oscillator_sleep_bit <= pwdata[`PSM_SYNTH_OSCSLEEP_BIT];
      end
    end
  end

  // --------------------------------------------------------------------
  // wake qualification
  // --------------------------------------------------------------------
  wire any_irq = |irq_sync;
  wire pd_wake = irq_sync[1]
               || (irq_sync[2] && serial_wake_enable)
               || (irq_sync[3] && external_wake_enable);

  psm_seq u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .any_irq (any_irq),
    .pd_wake (pd_wake),
    .ctl     (ctl)
  );

  // --------------------------------------------------------------------
  // clock and pin decode
  // --------------------------------------------------------------------
  wire in_idle  = (ctl.mode == psm_pkg::PSM_IDLE);
  wire in_pdown = (ctl.mode == psm_pkg::PSM_PDOWN);
  wire in_norm  = !in_idle && !in_pdown;

  wire next_core_clk_en = in_norm;
  wire next_osc_run     = !(in_pdown && oscillator_sleep_bit);
  wire next_synth_run   = !in_pdown;
  wire next_periph      = !in_pdown;
  wire next_tic_en      = next_osc_run;
  wire next_pin_hold    = !in_norm;
  wire next_dac_en      = !in_pdown;
  wire next_ale = in_idle  ? `PSM_STROBE_IDLE_LVL :
                  in_pdown ? `PSM_STROBE_PDOWN_LVL :
                  core_address_latch_strobe;
  wire next_pss = in_idle  ? `PSM_STROBE_IDLE_LVL :
                  in_pdown ? `PSM_STROBE_PDOWN_LVL :
                  core_program_store_strobe;

  wire [31:0] rd_pctl   = {28'h0000000, external_wake_enable, serial_wake_enable,
                           pdown_bit, idle_bit};
  wire [31:0] rd_synth  = {31'h00000000, oscillator_sleep_bit};
  wire [31:0] rd_status = {30'h00000000, ctl.mode};
  wire [31:0] next_rd   = sel_pctl  ? rd_pctl  :
                          sel_synth ? rd_synth :
                          sel_status ? rd_status : 32'h00000000;

  // --------------------------------------------------------------------
  // output flops
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_clk_en             <= 1'b1;
      osc_run                 <= 1'b1;
      synth_run               <= 1'b1;
      periph_clk_en           <= 1'b1;
      interval_counter_clk_en <= 1'b1;
      pin_hold                <= 1'b0;
      dac_out_en              <= 1'b1;
      address_latch_strobe    <= 1'b1;
      program_store_strobe    <= 1'b1;
      mode_out                <= 2'h0;
    end else if (clk_en) begin
      core_clk_en             <= next_core_clk_en;
      osc_run                 <= next_osc_run;
      synth_run               <= next_synth_run;
      periph_clk_en           <= next_periph;
      interval_counter_clk_en <= next_tic_en;
      pin_hold                <= next_pin_hold;
      dac_out_en              <= next_dac_en;
      address_latch_strobe    <= next_ale;
      program_store_strobe    <= next_pss;
      mode_out                <= ctl.mode;
    end
  end

  // apb answers in the setup cycle's next edge: one access cycle, no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !sel_any;
      prdata  <= (psel && !penable && !pwrite) ? next_rd : 32'h00000000;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);

  pdown_wins_a: assert property (
    ctl.mode == psm_pkg::PSM_NORMAL && pdown_bit && idle_bit && !ctl.wake
    |=> ctl.mode == psm_pkg::PSM_PDOWN)
    else $error("both bits did not give power-down");
  idle_strobes_a: assert property (
    in_idle |=> address_latch_strobe && program_store_strobe && pin_hold)
    else $error("idle strobes not high");
  pdown_pins_a: assert property (
    in_pdown |=> !address_latch_strobe && !program_store_strobe && !dac_out_en)
    else $error("power-down pins wrong");
  core_stop_a: assert property (
    in_idle |=> !core_clk_en && periph_clk_en && osc_run)
    else $error("idle clocks wrong");
  synth_stop_a: assert property (
    in_pdown |=> !synth_run && !core_clk_en && !periph_clk_en)
    else $error("power-down clocks wrong");
  osc_sleep_a: assert property (
    in_pdown |=> osc_run == !$past(oscillator_sleep_bit))
    else $error("oscillator ignores sleep bit");
  serial_gate_a: assert property (
    in_pdown && irq_sync == 4'h4 && !serial_wake_enable |=> in_pdown)
    else $error("serial woke without enable");
  ext_gate_a: assert property (
    in_pdown && irq_sync == 4'h8 && !external_wake_enable |=> in_pdown)
    else $error("external woke without enable");
  tic_wake_a: assert property (
    in_pdown && irq_sync[1] |=> in_norm ##1 !pdown_bit)
    else $error("interval counter did not wake");
  idle_wake_a: assert property (
    in_idle && any_irq |=> in_norm)
    else $error("interrupt did not end idle");

  idle_seen_c:  cover property (in_norm ##1 in_idle ##[1:20] in_norm);
  pdown_seen_c: cover property (in_norm ##1 in_pdown ##[1:20] in_norm);
  osc_off_c:    cover property (in_pdown && oscillator_sleep_bit);

endmodule

// ==== sim/power_saving_mode_control_tb.sv ====
// power_saving_mode_control_tb.sv: self-checking bench for psm_top.
// assumes: zero-wait APB slave; wake sources come from psm_core_model.
`timescale 1ns/100ps
`include "psm_map.svh"
module power_saving_mode_control_tb;
  // --------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------
  logic        pclk, presetn, clk_en, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, ale_core, pss_core;
  logic        core_clk_en, osc_run, synth_run, periph_clk_en, ic_clk_en;
  logic        pin_hold, dac_out_en, als, pss;
  logic [1:0]  mode_out;
  logic [3:0]  fire, irq;
  logic [10:0] pins;
  int          failures, compares, cycles;
  // core,osc,synth,periph,counter,hold,dac,strobes,mode
  localparam logic [10:0] NORMAL = 11'h7D0;
  localparam logic [10:0] IDLE   = 11'h3FD;
  localparam logic [10:0] PD_ON  = 11'h262;
  localparam logic [10:0] PD_OFF = 11'h022;
  assign pins = {core_clk_en, osc_run, synth_run, periph_clk_en, ic_clk_en,
                 pin_hold, dac_out_en, als, pss, mode_out};

  // --------------------------------------------------------------------
  // design and partner
  // --------------------------------------------------------------------
  psm_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .enabled_irq(irq[0]),
    .interval_counter_irq(irq[1]), .serial_irq(irq[2]),
    .external_interrupt_zero(irq[3]), .core_address_latch_strobe(ale_core),
    .core_program_store_strobe(pss_core), .core_clk_en(core_clk_en),
    .osc_run(osc_run), .synth_run(synth_run), .periph_clk_en(periph_clk_en),
    .interval_counter_clk_en(ic_clk_en), .pin_hold(pin_hold),
    .dac_out_en(dac_out_en), .address_latch_strobe(als),
    .program_store_strobe(pss), .mode_out(mode_out));
  psm_core_model core (.pclk(pclk), .presetn(presetn), .core_clk_en(core_clk_en),
    .fire(fire), .irq(irq), .ale_core(ale_core), .pss_core(pss_core));

  always #50 pclk = ~pclk;

  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // values read right after an edge are those sampled at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [32:0] r);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = {pslverr, prdata};
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic cmp_read(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t read got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pins(input logic [10:0] exp);
    logic [10:0] m;
    m = (exp == NORMAL) ? 11'h7F3 : 11'h7FF;
    compares++;
    if ((pins & m) !== exp) begin
      failures++;
      $display("mismatch at %0t pins got %h expected %h", $time, pins & m, exp);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    logic [32:0] r;
    apb(1'h0, a, 32'h0, r);
    cmp_read(r, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'h1, a, d, r);
  endtask

  // mode change shows two edges after the write completes
  task automatic enter(input logic [31:0] d);
    wr(`PSM_ADDR_POWER_CTRL, d);
    cyc(2);
  endtask

  // waits a bounded time for the core clock; returns asleep if no wake
  task automatic wake(input logic [3:0] src);
    int n;
    n = 0;
    fire <= src;
    @(posedge pclk);
    fire <= 4'h0;
    while (core_clk_en !== 1'h1 && n < 12) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    pclk = 0; presetn = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 12'h0; pwdata = 32'h0; fire = 4'h0; failures = 0; compares = 0;
    cycles = 0;
    cyc(16);
    presetn <= 1'h1;
    cyc(2);
    cmp_pins(NORMAL);
    rd(`PSM_ADDR_POWER_CTRL, 33'h0);
    rd(`PSM_ADDR_SYNTH_CTRL, 33'h0);
    wr(12'h00C, 32'h3);
    rd(12'h00C, 33'h100000000);
    rd(`PSM_ADDR_STATUS, 33'h0);
    $display("test reset_and_map done");
    enter(32'h1);
    cmp_pins(IDLE);
    rd(`PSM_ADDR_STATUS, 33'h1);
    wake(4'h1);
    cmp_pins(NORMAL);
    rd(`PSM_ADDR_POWER_CTRL, 33'h0);
    $display("test idle done");
    enter(32'h2);
    cmp_pins(PD_ON);
    wake(4'h1);
    cmp_pins(PD_ON);
    wake(4'h2);
    cmp_pins(NORMAL);
    rd(`PSM_ADDR_POWER_CTRL, 33'h0);
    $display("test pdown_counter_wake done");
    wr(`PSM_ADDR_SYNTH_CTRL, 32'h1);
    enter(32'h3);
    cmp_pins(PD_OFF);
    wake(4'h4);
    cmp_pins(PD_OFF);
    wake(4'h8);
    cmp_pins(PD_OFF);
    presetn <= 1'h0;
    cyc(2);
    presetn <= 1'h1;
    cyc(2);
    cmp_pins(NORMAL);
    rd(`PSM_ADDR_SYNTH_CTRL, 33'h0);
    $display("test pdown_reset done");
    enter(32'h6);
    wake(4'h4);
    cmp_pins(NORMAL);
    rd(`PSM_ADDR_POWER_CTRL, 33'h4);
    enter(32'hA);
    wake(4'h8);
    cmp_pins(NORMAL);
    rd(`PSM_ADDR_POWER_CTRL, 33'h8);
    $display("test pdown_enabled_wake done");
    report_and_stop();
  end
endmodule

// ==== sim/psm_core_model.sv ====
// psm_core_model.sv: behavioural core and interrupt sources facing the
// power-saving mode controller.
// assumes: the bench pulses fire for one cycle while the core sleeps.
`timescale 1ns/100ps
module psm_core_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // from controller and bench
  input  wire logic       core_clk_en,
  input  wire logic [3:0] fire,
  // towards controller
  output logic      [3:0] irq,
  output logic            ale_core,
  output logic            pss_core
);
  // a request stays pending until the core runs again and services it,
  // so a woken core never sees a stale level and re-enters at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq      <= 4'h0;
      ale_core <= 1'h0;
      pss_core <= 1'h1;
    end else begin
      irq <= (irq & ~{4{core_clk_en}}) | fire;
      if (core_clk_en) begin
        ale_core <= ~ale_core;
        pss_core <= ~pss_core;
      end
    end
  end
endmodule
